/* File: hw/relay_pkg.sv */
// constants for relay selection and start timing
package relay_pkg;
   localparam logic [7:0]  REG_RELAY_SEL   = 8'h1d;
   localparam logic [7:0]  REG_RUNUP_LIM   = 8'h20;
   localparam logic [7:0]  REG_START_DLY   = 8'h24;
   localparam logic [15:0] RELAY_SEL_RST   = 16'h0000;
   localparam logic [15:0] RUNUP_LIM_RST   = 16'h02d0;
   localparam logic [15:0] START_DLY_RST   = 16'h0000;
   localparam logic [15:0] RELAY_SEL_MAX   = 16'h0004;
   localparam logic [15:0] START_DLY_MAX   = 16'h00ff;
   localparam int          CTRL_VENT_BIT   = 12;
   localparam int          CTRL_PURGE_BIT  = 11;
   localparam int          CLK_HZ          = 100_000_000;
   localparam int          SEC_PER_TENTH_MIN = 6;
   localparam int          PERCENT_FULL    = 100;
endpackage : relay_pkg

/* File: hw/relay_select_start_timing.sv */
// relay routing, run-up supervision and start delay
`timescale 1ns/1ps
module relay_select_start_timing #(
   parameter int unsigned TICKS_PER_SEC = relay_pkg::CLK_HZ
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   // parameter port
   input  wire logic        par_wr_in,
   input  wire logic [7:0]  par_addr_in,
   input  wire logic [15:0] par_wdata_in,
   output logic      [15:0] par_rdata_out,
   output logic             par_err_out,
   // measurements and state
   input  wire logic [15:0] rotor_frequency_in,
   input  wire logic [15:0] setpoint_frequency_in,
   input  wire logic [15:0] normal_level_percent_in,
   input  wire logic [15:0] motor_current_setpoint_in,
   input  wire logic [15:0] current_normal_threshold_in,
   input  wire logic        error_in,
   input  wire logic [15:0] control_word_in,
   input  wire logic        start_in,
   // outputs
   output logic             normal_relay_out,
   output logic             error_relay_out,
   output logic             motor_enable_out,
   output logic             runup_fault_out
);
   logic [15:0] relay_function_select_r;
   logic [15:0] run_up_time_limit_r;
   logic [15:0] start_delay_time_r;
   logic        freq_ok;
   logic        curr_ok;
   logic [31:0] freq_scaled;
   logic [31:0] freq_target;
   logic [31:0] tick_r;
   logic        sec_tick;
   logic [15:0] dly_sec_r;
   logic [15:0] run_sec_r;
   logic        running_r;
   logic [15:0] dly_target;
   logic        start_s1_r;
   logic        start_s2_r;
   logic        start_s3_r;
   logic        start_r;

   // start command synchroniser, three stages
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         start_s1_r <= 1'b0;
         start_s2_r <= 1'b0;
         start_s3_r <= 1'b0;
      end else begin
         start_s1_r <= start_in;
         start_s2_r <= start_s1_r;
         start_s3_r <= start_s2_r;
      end
   end

   // change taken once stages two and three agree
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         start_r <= 1'b0;
      end else if (start_s2_r == start_s3_r) begin
         start_r <= start_s3_r;
      end
   end

   // parameter writes, range checks on relay select and start delay only
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         relay_function_select_r <= relay_pkg::RELAY_SEL_RST;
         run_up_time_limit_r     <= relay_pkg::RUNUP_LIM_RST;
         start_delay_time_r      <= relay_pkg::START_DLY_RST;
      end else if (par_wr_in) begin
         if (par_addr_in == relay_pkg::REG_RELAY_SEL &&
             par_wdata_in <= relay_pkg::RELAY_SEL_MAX) begin
            relay_function_select_r <= par_wdata_in;
         end
         if (par_addr_in == relay_pkg::REG_RUNUP_LIM) begin
            run_up_time_limit_r <= par_wdata_in;
         end
         if (par_addr_in == relay_pkg::REG_START_DLY &&
             par_wdata_in <= relay_pkg::START_DLY_MAX) begin
            start_delay_time_r <= par_wdata_in;
         end
      end
   end

   always_comb begin
      par_err_out = 1'b0;
      case (par_addr_in)
         relay_pkg::REG_RELAY_SEL: begin
            par_rdata_out = relay_function_select_r;
            par_err_out   = par_wr_in && (par_wdata_in > relay_pkg::RELAY_SEL_MAX);
         end
         relay_pkg::REG_RUNUP_LIM: par_rdata_out = run_up_time_limit_r;
         relay_pkg::REG_START_DLY: begin
            par_rdata_out = start_delay_time_r;
            par_err_out   = par_wr_in && (par_wdata_in > relay_pkg::START_DLY_MAX);
         end
         default: begin
            par_rdata_out = 16'h0000;
            par_err_out   = 1'b1;
         end
      endcase
   end

   // normal-operation criteria
   assign freq_scaled = {16'h0000, rotor_frequency_in} * 32'(relay_pkg::PERCENT_FULL);
   assign freq_target = {16'h0000, setpoint_frequency_in} * {16'h0000, normal_level_percent_in};
   assign freq_ok     = freq_scaled >= freq_target;
   assign curr_ok     = motor_current_setpoint_in <= current_normal_threshold_in;

   // relay routing, registered each cycle
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         normal_relay_out <= 1'b0;
         error_relay_out  <= 1'b0;
      end else begin
         case (relay_function_select_r[2:0])
            3'h0: begin
               normal_relay_out <= freq_ok;
               error_relay_out  <= error_in;
            end
            3'h1: begin
               normal_relay_out <= curr_ok;
               error_relay_out  <= error_in;
            end
            3'h2: begin
               normal_relay_out <= control_word_in[relay_pkg::CTRL_VENT_BIT];
               error_relay_out  <= control_word_in[relay_pkg::CTRL_PURGE_BIT];
            end
            3'h3: begin
               normal_relay_out <= freq_ok;
               error_relay_out  <= !error_in;
            end
            3'h4: begin
               normal_relay_out <= curr_ok;
               error_relay_out  <= !error_in;
            end
            default: begin
               normal_relay_out <= 1'b0;
               error_relay_out  <= 1'b0;
            end
         endcase
      end
   end

   // one-second tick while start is present
   assign sec_tick = tick_r == TICKS_PER_SEC - 1;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tick_r <= 32'h0;
      end else if (!start_r || sec_tick) begin
         tick_r <= 32'h0;
      end else begin
         tick_r <= tick_r + 32'h1;
      end
   end

   // start delay, then motor enable
   assign dly_target = 16'(start_delay_time_r * relay_pkg::SEC_PER_TENTH_MIN);
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dly_sec_r <= 16'h0;
         running_r <= 1'b0;
      end else if (!start_r) begin
         dly_sec_r <= 16'h0;
         running_r <= 1'b0;
      end else if (dly_sec_r >= dly_target) begin
         running_r <= 1'b1;
      end else if (sec_tick) begin
         dly_sec_r <= dly_sec_r + 16'h1;
      end
   end
   assign motor_enable_out = running_r;

   // run-up supervision
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         run_sec_r       <= 16'h0;
         runup_fault_out <= 1'b0;
      end else if (!start_r) begin
         run_sec_r       <= 16'h0;
         runup_fault_out <= 1'b0;
      end else if (running_r && !freq_ok && !runup_fault_out) begin
         if (run_sec_r >= run_up_time_limit_r) begin
            runup_fault_out <= 1'b1;
         end else if (sec_tick) begin
            run_sec_r <= run_sec_r + 16'h1;
         end
      end else if (freq_ok) begin
         run_sec_r <= 16'h0;
      end
   end

   a_sel_range: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      relay_function_select_r <= relay_pkg::RELAY_SEL_MAX) else $error("selector out of range");
   a_mode0_normal: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      relay_function_select_r == 16'h0 && $stable(relay_function_select_r)
      |=> normal_relay_out == $past(freq_ok)) else $error("mode 0 normal relay wrong");
   a_mode1_normal: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      relay_function_select_r == 16'h1 |=> normal_relay_out == $past(curr_ok))
      else $error("mode 1 normal relay wrong");
   a_mode2_vent: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      relay_function_select_r == 16'h2 |=> normal_relay_out == $past(control_word_in[12]))
      else $error("vent relay wrong");
   a_mode2_purge: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      relay_function_select_r == 16'h2 |=> error_relay_out == $past(control_word_in[11]))
      else $error("purge relay wrong");
   a_mode3_err: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      relay_function_select_r == 16'h3 |=> error_relay_out == !$past(error_in))
      else $error("mode 3 error relay wrong");
   a_mode4_err: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      relay_function_select_r == 16'h4 |=> error_relay_out == !$past(error_in))
      else $error("mode 4 error relay wrong");
   a_fault_start: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      runup_fault_out |-> running_r) else $error("fault without start");
   a_no_delay_go: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      start_r && start_delay_time_r == 16'h0 && !running_r |=> running_r || !start_r)
      else $error("zero delay start late");
   a_relay_track: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      relay_function_select_r == 16'h0 |=> error_relay_out == $past(error_in))
      else $error("relays not updated each cycle");

   // remaining relay modes
   a_mode1_err: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      relay_function_select_r == 16'h1 |=> error_relay_out == $past(error_in))
      else $error("mode 1 error relay wrong");
   a_mode3_normal: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      relay_function_select_r == 16'h3 |=> normal_relay_out == $past(freq_ok))
      else $error("mode 3 normal relay wrong");
   a_mode4_normal: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      relay_function_select_r == 16'h4 |=> normal_relay_out == $past(curr_ok))
      else $error("mode 4 normal relay wrong");

   // parameter port
   a_sel_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      par_wr_in && par_addr_in == relay_pkg::REG_RELAY_SEL &&
      par_wdata_in <= relay_pkg::RELAY_SEL_MAX
      |=> relay_function_select_r == $past(par_wdata_in))
      else $error("selector write lost");
   a_sel_refuse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      par_wr_in && par_addr_in == relay_pkg::REG_RELAY_SEL &&
      par_wdata_in > relay_pkg::RELAY_SEL_MAX |=> $stable(relay_function_select_r))
      else $error("selector took bad value");
   a_limit_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      par_wr_in && par_addr_in == relay_pkg::REG_RUNUP_LIM
      |=> run_up_time_limit_r == $past(par_wdata_in))
      else $error("run-up limit write lost");
   a_limit_read: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      par_addr_in == relay_pkg::REG_RUNUP_LIM |-> par_rdata_out == run_up_time_limit_r)
      else $error("run-up limit read wrong");
   a_dly_range: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      start_delay_time_r <= relay_pkg::START_DLY_MAX)
      else $error("start delay out of range");
   a_dly_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      par_wr_in && par_addr_in == relay_pkg::REG_START_DLY &&
      par_wdata_in <= relay_pkg::START_DLY_MAX
      |=> start_delay_time_r == $past(par_wdata_in))
      else $error("start delay write lost");
   a_dly_refuse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      par_wr_in && par_addr_in == relay_pkg::REG_START_DLY &&
      par_wdata_in > relay_pkg::START_DLY_MAX |=> $stable(start_delay_time_r))
      else $error("start delay took bad value");
   a_unmapped_err: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      par_addr_in != relay_pkg::REG_RELAY_SEL && par_addr_in != relay_pkg::REG_RUNUP_LIM &&
      par_addr_in != relay_pkg::REG_START_DLY |-> par_err_out && par_rdata_out == 16'h0000)
      else $error("unmapped access not flagged");

   // start delay and run-up supervision
   a_enable_wait: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      start_r && !running_r && dly_sec_r < dly_target |=> !running_r)
      else $error("motor enabled before delay");
   a_enable_drop: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !start_r |=> !motor_enable_out)
      else $error("motor enable held without start");
   a_start_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      start_s2_r != start_s3_r |=> $stable(start_r))
      else $error("start taken before stages agree");
   a_fault_rise: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      start_r && running_r && !freq_ok && !runup_fault_out &&
      run_sec_r >= run_up_time_limit_r |=> runup_fault_out)
      else $error("run-up fault missed");
   a_fault_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !start_r |=> !runup_fault_out)
      else $error("run-up fault held without start");
   a_tick_range: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      tick_r < TICKS_PER_SEC)
      else $error("second tick counter overran");
endmodule : relay_select_start_timing

/* File: bench/field_bus_model.sv */
// field bus master model that drives the control word
`timescale 1ns/1ps
module field_bus_model (
   // valve requests
   input  wire logic        vent_in,
   input  wire logic        purge_in,
   // control word
   output logic      [15:0] control_word_out
);
   // relay bits only matter in interface operation, other bits stay clear
   always_comb begin
      control_word_out     = 16'h0000;
      control_word_out[12] = vent_in;
      control_word_out[11] = purge_in;
   end
endmodule : field_bus_model

/* File: bench/relay_select_start_timing_tb.sv */
// self-checking bench for relay routing and start timing
`timescale 1ns/1ps
module relay_select_start_timing_tb;
   logic        clk_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic        par_wr, err_in, start, vent, purge, nrel, erel, men, flt, perr, en, ee;
   logic [7:0]  addr;
   logic [15:0] wdata, rotor, motor, cw, rdata;
   int          errors = 0;
   int          check_count = 0;
   always #5 clk_in = ~clk_in;
   field_bus_model field_bus_model_inst (.vent_in(vent), .purge_in(purge), .control_word_out(cw));
   relay_select_start_timing #(.TICKS_PER_SEC(10)) relay_select_start_timing_inst (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .par_wr_in(par_wr), .par_addr_in(addr),
      .par_wdata_in(wdata), .par_rdata_out(rdata), .par_err_out(perr),
      .rotor_frequency_in(rotor), .setpoint_frequency_in(16'h0320),
      .normal_level_percent_in(16'h005a), .motor_current_setpoint_in(motor),
      .current_normal_threshold_in(16'h0014), .error_in(err_in), .control_word_in(cw),
      .start_in(start), .normal_relay_out(nrel), .error_relay_out(erel),
      .motor_enable_out(men), .runup_fault_out(flt));
   task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic e);
      addr = a;
      wdata = d;
      par_wr = 1'b1;
      #1 check("par_err", {15'h0, e}, {15'h0, perr});
      @(negedge clk_in);
      par_wr = 1'b0;
      @(negedge clk_in);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic e);
      addr = a;
      #1 check("par_rdata", d, rdata);
      check("par_err", {15'h0, e}, {15'h0, perr});
      @(negedge clk_in);
   endtask : rd
   task automatic end_sim;
      if (errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim
   initial begin
      #200000;
      errors++;
      end_sim();
   end
   initial begin
      par_wr = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      rotor = 16'h0000;
      motor = 16'h0000;
      err_in = 1'b0;
      start = 1'b0;
      vent = 1'b0;
      purge = 1'b0;
      cyc(6);
      rst_b_in = 1'b1;
      cyc(1);
      rd(8'h1d, 16'h0000, 1'b0);
      rd(8'h20, 16'h02d0, 1'b0);
      rd(8'h24, 16'h0000, 1'b0);
      rd(8'h21, 16'h0000, 1'b1);
      wr(8'h1d, 16'h0005, 1'b1);
      rd(8'h1d, 16'h0000, 1'b0);
      for (int m = 4; m >= 0; m--) begin
         wr(8'h1d, 16'(m), 1'b0);
         rd(8'h1d, 16'(m), 1'b0);
         for (int c = 0; c < 4; c++) begin
            rotor = c[0] ? 16'h02d0 : 16'h02cf;
            motor = c[1] ? 16'h0014 : 16'h0015;
            err_in = c[0] ^ c[1];
            vent = ~c[0];
            purge = c[1];
            en = (m == 2) ? ~c[0] : (m % 3 == 1) ? c[1] : c[0];
            ee = (m == 2) ? c[1] : (m > 2) ? ~err_in : err_in;
            cyc(1);
            check("normal_relay", {15'h0, en}, {15'h0, nrel});
            check("error_relay", {15'h0, ee}, {15'h0, erel});
         end
      end
      wr(8'h24, 16'h0100, 1'b1);
      wr(8'h24, 16'h0001, 1'b0);
      start = 1'b1;
      cyc(55);
      check("motor_enable", 16'h0000, {15'h0, men});
      cyc(15);
      check("motor_enable", 16'h0001, {15'h0, men});
      start = 1'b0;
      cyc(6);
      wr(8'h24, 16'h0000, 1'b0);
      wr(8'h20, 16'h0002, 1'b0);
      rotor = 16'h02cf;
      start = 1'b1;
      cyc(15);
      check("runup_fault", 16'h0000, {15'h0, flt});
      cyc(15);
      check("runup_fault", 16'h0001, {15'h0, flt});
      start = 1'b0;
      cyc(6);
      check("runup_fault", 16'h0000, {15'h0, flt});
      check("motor_enable", 16'h0000, {15'h0, men});
      rst_b_in = 1'b0;
      cyc(2);
      rd(8'h20, 16'h02d0, 1'b0);
      check("normal_relay", 16'h0000, {15'h0, nrel});
      rst_b_in = 1'b1;
      cyc(2);
      rd(8'h1d, 16'h0000, 1'b0);
      end_sim();
   end
endmodule : relay_select_start_timing_tb
